// *** rtl/cad_core.sv ***
// Purpose: CPU core registers, ALU wrapper and operand address forming
// Assumes: One clock; memory word for indirect/indexed arrives as mem_word
// Notes:   All address arithmetic wraps in 16 bits
// Summary of operation
// - ALU is 16 bits, add/sub/shift/logic complete in one cycle.
// - ALU keeps separate signed and unsigned overflow flags.
// - Accumulator is source and destination for most operations.
// - Two pointer registers address memory and can auto count up or down.
// - Boundary register holds loop limit for first pointer; also a pointer.
// - Stack pointer plus two on push/call, minus two on pop/return.
// - Stack anywhere in memory; stack pointer is not a register indirect source.
// - Program counter supplies program fetch address.
// - 32-bit product register loads results and shifts right arithmetically.
// - Register indirect takes address from accumulator, pointers or boundary.
// - Direct mode address is the 8 or 16 bit instruction field.
// - Indirect mode uses word at 8-bit field as operand address.
// - Indexed mode adds word at 8-bit field to displacement.
// - Immediate mode operand is the 8 or 16 bit field.
// - Auto mode uses second pointer, then steps by 1 byte or 2 word.
// - First pointer auto steps, compares with boundary, skip when passed.
// - Word accesses always land on even byte addresses.
`include "cad_defs.svh"
`default_nettype none
module cad_core (
	input  wire logic             core_clk,   // System clock
	input  wire logic             rst_n,      // Synchronous reset, active low
	input  wire cad_pkg::cad_cmd_t cmd,       // Per-cycle control
	input  wire cad_pkg::cad_word_t mem_word, // Word read at 8-bit field
	output var cad_pkg::cad_regs_t  regs,        // Register state
	output var cad_pkg::cad_word_t  oper_addr,   // Operand address
	output logic                    oper_is_imm, // Operand is immediate value
	output var cad_pkg::cad_word_t  imm_value,   // Immediate operand
	output logic                    skip,        // Skip next instruction
	output var cad_pkg::cad_word_t  fetch_addr   // Program fetch address
);
	import cad_pkg::*;
	typedef struct packed {
		cad_regs_t r;
		cad_word_t addr;
		logic      imm;
		cad_word_t immv;
		logic      skip;
	} cad_state_t;
	cad_state_t state_ff, nxt_state;
	cad_word_t alu_res;
	logic alu_arith, alu_v, alu_c;

	function automatic cad_word_t sel_reg(input cad_regs_t r, input cad_reg_sel_t s);
		case (s)
			CAD_REG_A: sel_reg = r.acc;
			CAD_REG_B: sel_reg = r.ptr_b;
			CAD_REG_X: sel_reg = r.ptr_x;
			default:   sel_reg = r.bound_k;
		endcase
	endfunction : sel_reg
	function automatic cad_word_t field_val(input cad_word_t f, input logic wide);
		field_val = wide ? f : {8'h00, f[7:0]};
	endfunction : field_val
	function automatic cad_word_t align(input cad_word_t a, input logic word);
		align = word ? {a[15:1], 1'b0} : a;
	endfunction : align

	cad_alu #(.WIDTH(`CAD_DATA_W)) u_alu (
		.opa    (state_ff.r.acc),
		.opb    (field_val(cmd.field, cmd.field_wide)),
		.op     (cmd.alu_op),
		.result (alu_res),
		.arith  (alu_arith),
		.v_out  (alu_v),
		.c_out  (alu_c)
	);

	always_comb begin
		cad_word_t step;
		cad_word_t nb;
		step = cmd.word_op ? `CAD_STEP_WORD : `CAD_STEP_BYTE;
		nb   = '0;
		nxt_state = state_ff;
		nxt_state.skip = 1'b0;
		if (cmd.alu_to_acc) begin
			nxt_state.r.acc = alu_res;
			if (alu_arith) begin
				nxt_state.r.ovf_signed   = alu_v;
				nxt_state.r.ovf_unsigned = alu_c;
			end
		end
		if (cmd.reg_wr) begin
			case (cmd.reg_wr_sel)
				3'h0: nxt_state.r.acc = cmd.reg_wr_data;
				3'h1: nxt_state.r.ptr_b = cmd.reg_wr_data;
				3'h2: nxt_state.r.ptr_x = cmd.reg_wr_data;
				3'h3: nxt_state.r.bound_k = cmd.reg_wr_data;
				3'h4: nxt_state.r.stack_top_ptr = cmd.reg_wr_data;
				default: ;
			endcase
		end
		case (cmd.sp_op)
			CAD_SP_PUSH: nxt_state.r.stack_top_ptr = state_ff.r.stack_top_ptr + `CAD_SP_STEP;
			CAD_SP_POP:  nxt_state.r.stack_top_ptr = state_ff.r.stack_top_ptr - `CAD_SP_STEP;
			default: ;
		endcase
		if (cmd.pc_load)
			nxt_state.r.fetch_address_counter = cmd.pc_value;
		else if (cmd.pc_inc)
			nxt_state.r.fetch_address_counter = state_ff.r.fetch_address_counter + 16'h0001;
		case (cmd.prod_op)
			CAD_PR_LOAD: nxt_state.r.product_result_reg = cmd.prod_in;
			CAD_PR_ARITH_RIGHT_SHIFT_OP: nxt_state.r.product_result_reg =
				$signed(state_ff.r.product_result_reg) >>> 1;
			default: ;
		endcase
		if (cmd.addr_go) begin
			nxt_state.imm = 1'b0;
			case (cmd.amode)
				CAD_AM_REGIND: nxt_state.addr =
					align(sel_reg(state_ff.r, cmd.ind_sel), cmd.word_op);
				CAD_AM_DIRECT: nxt_state.addr =
					align(field_val(cmd.field, cmd.field_wide), cmd.word_op);
				CAD_AM_INDIRECT: nxt_state.addr = align(mem_word, cmd.word_op);
				CAD_AM_INDEXED: nxt_state.addr =
					align(mem_word + field_val(cmd.disp, cmd.disp_wide), cmd.word_op);
				CAD_AM_IMMED: begin
					nxt_state.imm  = 1'b1;
					nxt_state.immv = field_val(cmd.field, cmd.field_wide);
				end
				CAD_AM_AUTOX: begin
					nxt_state.addr = align(state_ff.r.ptr_x, cmd.word_op);
					nxt_state.r.ptr_x = cmd.step_down ? state_ff.r.ptr_x - step
						: state_ff.r.ptr_x + step;
				end
				CAD_AM_AUTOB: begin
					nxt_state.addr = align(state_ff.r.ptr_b, cmd.word_op);
					nb = cmd.step_down ? state_ff.r.ptr_b - step : state_ff.r.ptr_b + step;
					nxt_state.r.ptr_b = nb;
					nxt_state.skip = cmd.step_down ? (nb < state_ff.r.bound_k)
						: (nb > state_ff.r.bound_k);
				end
				default: ;
			endcase
		end
		if (!rst_n) begin
			nxt_state = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		state_ff <= nxt_state;
	end

	assign regs        = state_ff.r;
	assign oper_addr   = state_ff.addr;
	assign oper_is_imm = state_ff.imm;
	assign imm_value   = state_ff.immv;
	assign skip        = state_ff.skip;
	assign fetch_addr  = state_ff.r.fetch_address_counter;

	a_sp_push_two: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.sp_op == CAD_SP_PUSH && !cmd.reg_wr |=>
		regs.stack_top_ptr == $past(regs.stack_top_ptr) + 16'h0002)
		else $error("stack push step wrong");
	a_sp_pop_two: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.sp_op == CAD_SP_POP && !cmd.reg_wr |=>
		regs.stack_top_ptr == $past(regs.stack_top_ptr) - 16'h0002)
		else $error("stack pop step wrong");
	a_word_even_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.addr_go && cmd.word_op && cmd.amode != CAD_AM_IMMED |=> !oper_addr[0])
		else $error("odd word address");
	a_autox_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.addr_go && cmd.amode == CAD_AM_AUTOX && !cmd.step_down && !cmd.reg_wr |=>
		oper_addr == align($past(regs.ptr_x), $past(cmd.word_op)) &&
		regs.ptr_x == $past(regs.ptr_x) + ($past(cmd.word_op) ? 16'h0002 : 16'h0001))
		else $error("auto pointer step wrong");
	a_skip_only_b: assert property (@(posedge core_clk) disable iff (!rst_n)
		skip |-> $past(cmd.addr_go) && $past(cmd.amode) == CAD_AM_AUTOB)
		else $error("spurious skip");
	a_prod_arith_right_shift_op: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.prod_op == CAD_PR_ARITH_RIGHT_SHIFT_OP |=> regs.product_result_reg ==
		{$past(regs.product_result_reg[31]), $past(regs.product_result_reg[31:1])})
		else $error("product shift wrong");
	a_pc_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.pc_inc && !cmd.pc_load |=> fetch_addr == $past(fetch_addr) + 16'h0001)
		else $error("fetch counter step wrong");
	a_add_result: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.alu_to_acc && cmd.alu_op == CAD_ALU_ADD && !cmd.reg_wr |=>
		{regs.ovf_unsigned, regs.acc} == {1'b0, $past(regs.acc)} +
		{1'b0, $past(field_val(cmd.field, cmd.field_wide))})
		else $error("add result or carry wrong");
	a_imm_value: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd.addr_go && cmd.amode == CAD_AM_IMMED && !cmd.field_wide |=>
		oper_is_imm && imm_value[15:8] == 8'h00)
		else $error("short immediate not zero extended");
endmodule : cad_core
`default_nettype wire

// *** shared/cad_defs.svh ***
// Purpose: Constants for the CPU core address datapath
// Assumes: 16-bit byte-addressed space
// Notes:   Included by package and rtl
`ifndef CAD_DEFS_SVH
`define CAD_DEFS_SVH
`define CAD_DATA_W      16
`define CAD_PROD_W      32
`define CAD_STEP_BYTE   16'h0001
`define CAD_STEP_WORD   16'h0002
`define CAD_SP_STEP     16'h0002
`define CAD_RST_VAL     16'h0000
`define CAD_RST_PROD    32'h0000_0000
`endif

// *** shared/cad_pkg.sv ***
// Purpose: Types for the CPU core address datapath
// Assumes: cad_defs.svh on the include path
// Notes:   Enumerations for ALU, register, mode and product selects
`include "cad_defs.svh"
`default_nettype none
package cad_pkg;
	typedef logic [`CAD_DATA_W-1:0] cad_word_t;
	typedef enum logic [2:0] {CAD_ALU_NOP, CAD_ALU_ADD, CAD_ALU_SUB, CAD_ALU_SHL,
		CAD_ALU_SHR, CAD_ALU_AND, CAD_ALU_OR, CAD_ALU_XOR} cad_alu_op_t;
	typedef enum logic [1:0] {CAD_REG_A, CAD_REG_B, CAD_REG_X, CAD_REG_K} cad_reg_sel_t;
	typedef enum logic [2:0] {CAD_AM_REGIND, CAD_AM_DIRECT, CAD_AM_INDIRECT,
		CAD_AM_INDEXED, CAD_AM_IMMED, CAD_AM_AUTOX, CAD_AM_AUTOB} cad_amode_t;
	typedef enum logic [1:0] {CAD_PR_HOLD, CAD_PR_LOAD, CAD_PR_ARITH_RIGHT_SHIFT_OP} cad_prod_op_t;
	typedef enum logic [1:0] {CAD_SP_HOLD, CAD_SP_PUSH, CAD_SP_POP} cad_sp_op_t;
	typedef struct packed {
		cad_alu_op_t  alu_op;
		logic         alu_to_acc;
		cad_amode_t   amode;
		cad_reg_sel_t ind_sel;
		logic         word_op;
		logic         step_down;
		logic         addr_go;
		cad_word_t    field;
		logic         field_wide;
		cad_word_t    disp;
		logic         disp_wide;
		cad_sp_op_t   sp_op;
		logic         pc_load;
		logic         pc_inc;
		cad_word_t    pc_value;
		logic         reg_wr;
		logic [2:0]   reg_wr_sel;
		cad_word_t    reg_wr_data;
		cad_prod_op_t prod_op;
		logic [`CAD_PROD_W-1:0] prod_in;
	} cad_cmd_t;
	typedef struct packed {
		cad_word_t acc;
		cad_word_t ptr_b;
		cad_word_t ptr_x;
		cad_word_t bound_k;
		cad_word_t stack_top_ptr;
		cad_word_t fetch_address_counter;
		logic [`CAD_PROD_W-1:0] product_result_reg;
		logic      ovf_signed;
		logic      ovf_unsigned;
	} cad_regs_t;
endpackage : cad_pkg
`default_nettype wire

// *** rtl/cad_alu.sv ***
// Purpose: 16-bit single cycle ALU
// Assumes: Purely combinational
// Notes:   Flags valid for add and subtract only
`default_nettype none
module cad_alu #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0]  opa,       // First operand
	input  wire logic [WIDTH-1:0]  opb,       // Second operand
	input  wire cad_pkg::cad_alu_op_t op,     // Operation
	output logic [WIDTH-1:0]       result,    // Result
	output logic                   arith,     // Op updates flags
	output logic                   v_out,     // Signed overflow
	output logic                   c_out      // Carry, or inverted borrow on subtract
);
	import cad_pkg::*;
	// Shift slices need at least two bits
	if (WIDTH < 2) begin : g_width_check
		$error("cad_alu WIDTH too small");
	end
	logic [WIDTH:0] sum;
	always_comb begin
		sum    = '0;
		result = '0;
		arith  = 1'b0;
		v_out  = 1'b0;
		c_out  = 1'b0;
		case (op)
			CAD_ALU_ADD: begin
				sum    = {1'b0, opa} + {1'b0, opb};
				result = sum[WIDTH-1:0];
				arith  = 1'b1;
				c_out  = sum[WIDTH];
				v_out  = (opa[WIDTH-1] == opb[WIDTH-1]) && (result[WIDTH-1] != opa[WIDTH-1]);
			end
			CAD_ALU_SUB: begin
				sum    = {1'b0, opa} - {1'b0, opb};
				result = sum[WIDTH-1:0];
				arith  = 1'b1;
				c_out  = ~sum[WIDTH];
				v_out  = (opa[WIDTH-1] != opb[WIDTH-1]) && (result[WIDTH-1] != opa[WIDTH-1]);
			end
			CAD_ALU_SHL: result = {opa[WIDTH-2:0], 1'b0};
			CAD_ALU_SHR: result = {1'b0, opa[WIDTH-1:1]};
			CAD_ALU_AND: result = opa & opb;
			CAD_ALU_OR:  result = opa | opb;
			CAD_ALU_XOR: result = opa ^ opb;
			default:     result = opa;
		endcase
	end
endmodule : cad_alu
`default_nettype wire

// *** tb/cad_mem_model.sv ***
// Purpose: Memory holding the words picked by the 8-bit field
// Assumes: Combinational read, valid in the cycle of addr_go
// Notes:   The word at even byte address a holds {a, 8'hC3}
`default_nettype none
module cad_mem_model (
	input  wire logic [7:0]          word_sel, // Byte address of the word
	output var  cad_pkg::cad_word_t  mem_word  // Word read there
);
	timeunit 1ns;
	timeprecision 1ps;
	import cad_pkg::*;
	// Words sit on even byte addresses
	assign mem_word = {word_sel & 8'hFE, 8'hC3};
endmodule : cad_mem_model
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for cad_core
// Assumes: One command per two cycles, results one edge later
// Notes:   Memory words come from cad_mem_model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cad_pkg::*;
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	cad_cmd_t   cmd = '0;
	cad_regs_t  regs;
	cad_word_t  mem_word;
	cad_word_t  oper_addr;
	cad_word_t  imm_value;
	cad_word_t  fetch_addr;
	logic       oper_is_imm;
	logic       skip;
	int         num_errors = 0;
	int         num_checks = 0;
	cad_core uut (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .mem_word(mem_word),
		.regs(regs), .oper_addr(oper_addr), .oper_is_imm(oper_is_imm),
		.imm_value(imm_value), .skip(skip), .fetch_addr(fetch_addr));
	cad_mem_model mem (.word_sel(cmd.field[7:0]), .mem_word(mem_word));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [159:0] exp, input logic [159:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic run(input cad_cmd_t c);
		@(posedge core_clk);
		cmd <= c;
		@(posedge core_clk);
		cmd <= '0;
		#1;
	endtask : run
	task automatic wr(input logic [2:0] sel, input cad_word_t d);
		cad_cmd_t c;
		c = '0;
		c.reg_wr = 1'b1;
		c.reg_wr_sel = sel;
		c.reg_wr_data = d;
		run(c);
	endtask : wr
	task automatic alu(input cad_alu_op_t op, input cad_word_t f, input cad_word_t ea,
		input logic [1:0] evc);
		cad_cmd_t c;
		c = '0;
		c.alu_op = op;
		c.alu_to_acc = 1'b1;
		c.field = f;
		c.field_wide = 1'b1;
		run(c);
		chk("acc", ea, regs.acc);
		chk("v_c", evc, {regs.ovf_signed, regs.ovf_unsigned});
	endtask : alu
	task automatic am(input cad_amode_t m, input cad_reg_sel_t s, input logic w, input logic dn,
		input cad_word_t f, input logic fw, input cad_word_t d, input logic dw,
		input cad_word_t ea);
		cad_cmd_t c;
		c = '0;
		c.addr_go = 1'b1;
		c.amode = m;
		c.ind_sel = s;
		c.word_op = w;
		c.step_down = dn;
		c.field = f;
		c.field_wide = fw;
		c.disp = d;
		c.disp_wide = dw;
		run(c);
		chk("oper_addr", ea, oper_addr);
		chk("is_imm", 1'b0, oper_is_imm);
	endtask : am
	task automatic op_misc(input cad_sp_op_t sp, input cad_prod_op_t po, input logic pl,
		input logic pi);
		cad_cmd_t c;
		c = '0;
		c.sp_op = sp;
		c.prod_op = po;
		c.prod_in = 32'h8000_0001;
		c.pc_load = pl;
		c.pc_inc = pi;
		c.pc_value = 16'h1234;
		run(c);
	endtask : op_misc
	task automatic t_alu();
		wr(3'd0, 16'h7FFF);
		alu(CAD_ALU_ADD, 16'h0001, 16'h8000, 2'b10);
		alu(CAD_ALU_ADD, 16'h8000, 16'h0000, 2'b11);
		alu(CAD_ALU_XOR, 16'h00FF, 16'h00FF, 2'b11);
		alu(CAD_ALU_SHL, 16'h0000, 16'h01FE, 2'b11);
		alu(CAD_ALU_SUB, 16'h0200, 16'hFFFE, 2'b00);
		alu(CAD_ALU_OR, 16'h0001, 16'hFFFF, 2'b00);
		alu(CAD_ALU_AND, 16'h00F0, 16'h00F0, 2'b00);
		alu(CAD_ALU_SHR, 16'h0000, 16'h0078, 2'b00);
		alu(CAD_ALU_SUB, 16'h0008, 16'h0070, 2'b01);
		alu(CAD_ALU_SUB, 16'h8000, 16'h8070, 2'b10);
		alu(CAD_ALU_ADD, 16'h8000, 16'h0070, 2'b11);
	endtask : t_alu
	task automatic t_stack_pc_prod();
		wr(3'd4, 16'hFFFE);
		op_misc(CAD_SP_PUSH, CAD_PR_LOAD, 1'b1, 1'b0);
		chk("sp_push", 16'h0000, regs.stack_top_ptr);
		chk("pc_load", 16'h1234, fetch_addr);
		chk("prod_load", 32'h8000_0001, regs.product_result_reg);
		op_misc(CAD_SP_POP, CAD_PR_ARITH_RIGHT_SHIFT_OP, 1'b0, 1'b1);
		chk("sp_pop", 16'hFFFE, regs.stack_top_ptr);
		chk("pc_inc", 16'h1235, regs.fetch_address_counter);
		chk("prod_arith_right_shift_op", 32'hC000_0000, regs.product_result_reg);
	endtask : t_stack_pc_prod
	task automatic t_auto();
		wr(3'd1, 16'h0010);
		wr(3'd3, 16'h0012);
		am(CAD_AM_AUTOB, CAD_REG_B, 1'b1, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0010);
		chk("b_step", 16'h0012, regs.ptr_b);
		chk("skip_eq", 1'b0, skip);
		am(CAD_AM_AUTOB, CAD_REG_B, 1'b1, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0012);
		chk("skip_past", 1'b1, skip);
		@(posedge core_clk);
		#1;
		chk("skip_pulse", 1'b0, skip);
		am(CAD_AM_AUTOB, CAD_REG_B, 1'b1, 1'b1, '0, 1'b0, '0, 1'b0, 16'h0014);
		chk("skip_dn_eq", 1'b0, skip);
		am(CAD_AM_AUTOB, CAD_REG_B, 1'b0, 1'b1, '0, 1'b0, '0, 1'b0, 16'h0012);
		chk("skip_dn_past", 1'b1, skip);
		chk("b_dn", 16'h0011, regs.ptr_b);
		wr(3'd2, 16'h0000);
		am(CAD_AM_AUTOX, CAD_REG_X, 1'b0, 1'b1, '0, 1'b0, '0, 1'b0, 16'h0000);
		chk("x_wrap", 16'hFFFF, regs.ptr_x);
		am(CAD_AM_AUTOX, CAD_REG_X, 1'b1, 1'b0, '0, 1'b0, '0, 1'b0, 16'hFFFE);
		chk("x_word", 16'h0001, regs.ptr_x);
	endtask : t_auto
	task automatic t_modes();
		cad_cmd_t c;
		am(CAD_AM_REGIND, CAD_REG_K, 1'b0, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0012);
		am(CAD_AM_REGIND, CAD_REG_A, 1'b0, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0070);
		am(CAD_AM_REGIND, CAD_REG_X, 1'b0, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0001);
		am(CAD_AM_REGIND, CAD_REG_B, 1'b1, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0010);
		am(CAD_AM_DIRECT, CAD_REG_A, 1'b0, 1'b0, 16'h1234, 1'b0, '0, 1'b0, 16'h0034);
		am(CAD_AM_DIRECT, CAD_REG_A, 1'b0, 1'b0, 16'h1235, 1'b1, '0, 1'b0, 16'h1235);
		am(CAD_AM_INDIRECT, CAD_REG_A, 1'b0, 1'b0, 16'h0040, 1'b0, '0, 1'b0, 16'h40C3);
		am(CAD_AM_INDEXED, CAD_REG_A, 1'b0, 1'b0, 16'h0042, 1'b0, 16'hABF0, 1'b0,
			16'h43B3);
		am(CAD_AM_INDEXED, CAD_REG_A, 1'b0, 1'b0, 16'h0042, 1'b0, 16'hC000, 1'b1,
			16'h02C3);
		c = '0;
		c.addr_go = 1'b1;
		c.amode = CAD_AM_IMMED;
		c.field = 16'h12AB;
		run(c);
		chk("imm_flag", 1'b1, oper_is_imm);
		chk("imm_value", 16'h00AB, imm_value);
	endtask : t_modes
	task automatic t_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk("rst_regs", '0, regs);
		chk("rst_outs", '0, {oper_addr, oper_is_imm, imm_value, skip});
		am(CAD_AM_REGIND, CAD_REG_B, 1'b1, 1'b0, '0, 1'b0, '0, 1'b0, 16'h0000);
	endtask : t_reset
	initial begin
		#50000;
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		chk("reset_regs", '0, regs);
		t_alu();
		t_stack_pc_prod();
		t_auto();
		t_modes();
		t_reset();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
